/* File: uof_flags.sv */
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Input-low flag sets while the supply comparator reports input low.
// - Input-low flag clears itself once the supply is back above level.
// - Lockout control bit 7 enables lockout circuit; resets to 0.
// - Lockout control bits 5-0 hold the six-bit threshold code.
// - Lockout control bit 6 reads zero; writes ignored.
// - Both flags set regardless of any interrupt enable.
// - Overcurrent during high-side conduction ends the pulse and sets flag.
// - High-side drive restarts next switching cycle; ends again on overcurrent.
// - Software clears overcurrent flag; sets again unless a clean cycle passed.
// - Comparator ignored for selected blanking time after high-side turn-on.
// - Overcurrent control bit 7 enables detection; resets to 0.
// - Overcurrent control bits 4-0 hold the five-bit limit code.
module uof_flags (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Analog front end
    input  wire logic            uv_comp_in,
    input  wire logic            oc_comp_in,
    output uof_pkg::uof_dac_t    dac_cfg,
    // Switching control
    input  wire logic            cycle_start,
    input  wire logic            hs_demand,
    output logic                 hs_drive,
    // Interrupt
    output logic                 irq
);
    import uof_pkg::*;

    typedef struct packed {
        logic [7:0]  lock_ctrl;
        logic [7:0]  oc_ctrl;
        logic [1:0]  mask;
        logic [31:0] rdata;
        logic        uv_meta;
        logic        uv_sync;
        logic        oc_meta;
        logic        oc_sync;
        logic        input_low_flag;
        logic        overcurrent_flag;
        logic        oc_pending;
        logic        oc_seen;
        logic        hs_allow;
        logic        hs_drive;
        logic [7:0]  blank_cnt;
    } uof_state_t;

    uof_state_t st_ff;
    uof_state_t nxt_st;

    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic wr_lock;
    logic wr_oc;
    logic wr_mask;
    logic rd_clr;
    logic oc_event;
    logic [1:0] status;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign addr_ok   = paddr == UOF_LOCK_CTRL_OFS || paddr == UOF_OC_CTRL_OFS
                    || paddr == UOF_STATUS_OFS || paddr == UOF_MASK_OFS;
    assign wr_lock   = access_ph && pwrite && paddr == UOF_LOCK_CTRL_OFS;
    assign wr_oc     = access_ph && pwrite && paddr == UOF_OC_CTRL_OFS;
    assign wr_mask   = access_ph && pwrite && paddr == UOF_MASK_OFS;
    // Only bits that were actually returned are cleared, so no late set is lost
    assign rd_clr    = access_ph && !pwrite && paddr == UOF_STATUS_OFS
                    && st_ff.rdata[UOF_ST_OC_BIT];

    // Blanked, enabled, synchronised overcurrent during conduction
    assign oc_event = st_ff.oc_sync && st_ff.hs_drive
                   && st_ff.oc_ctrl[UOF_OC_EN_BIT]
                   && st_ff.blank_cnt == 8'h00;

    assign status = {st_ff.overcurrent_flag, st_ff.input_low_flag};

    always_comb begin
        nxt_st = st_ff;
        // Two-stage synchronisers
        nxt_st.uv_meta = uv_comp_in;
        nxt_st.uv_sync = st_ff.uv_meta;
        nxt_st.oc_meta = oc_comp_in;
        nxt_st.oc_sync = st_ff.oc_meta;

        // Register writes
        if (wr_lock) begin
            nxt_st.lock_ctrl = pwdata[7:0];
            nxt_st.lock_ctrl[UOF_LOCK_RSVD_BIT] = 1'b0;
        end
        if (wr_oc) begin
            nxt_st.oc_ctrl = pwdata[7:0];
        end
        if (wr_mask) begin
            nxt_st.mask = pwdata[1:0];
        end

        // Read data captured in the setup phase
        if (setup_ph) begin
            nxt_st.rdata = 32'h0000_0000;
            unique case (paddr)
                UOF_LOCK_CTRL_OFS: nxt_st.rdata[7:0] = st_ff.lock_ctrl;
                UOF_OC_CTRL_OFS:   nxt_st.rdata[7:0] = st_ff.oc_ctrl;
                UOF_STATUS_OFS:    nxt_st.rdata[1:0] = status;
                UOF_MASK_OFS:      nxt_st.rdata[1:0] = st_ff.mask;
                default:           nxt_st.rdata = 32'h0000_0000;
            endcase
        end

        // Input-low flag follows the comparator, no software clear
        nxt_st.input_low_flag = st_ff.uv_sync
                             && st_ff.lock_ctrl[UOF_LOCK_EN_BIT];

        // Clean switching cycle releases the pending re-set
        if (cycle_start) begin
            if (!st_ff.oc_seen) begin
                nxt_st.oc_pending = 1'b0;
            end
            nxt_st.oc_seen = 1'b0;
        end
        if (oc_event) begin
            nxt_st.oc_seen    = 1'b1;
            nxt_st.oc_pending = 1'b1;
        end

        // Sticky overcurrent flag; set wins over the read clear
        nxt_st.overcurrent_flag = (st_ff.overcurrent_flag && !rd_clr)
                               || oc_event || st_ff.oc_pending;

        // High-side permission: cut on overcurrent, rearm each cycle
        if (cycle_start) begin
            nxt_st.hs_allow = 1'b1;
        end else if (oc_event) begin
            nxt_st.hs_allow = 1'b0;
        end
        nxt_st.hs_drive = hs_demand && nxt_st.hs_allow;

        // Leading-edge blanking counter loaded at each turn-on
        if (nxt_st.hs_drive && !st_ff.hs_drive) begin
            nxt_st.blank_cnt = uof_blank_cycles(
                st_ff.oc_ctrl[UOF_BLANK_LSB +: 2]);
        end else if (st_ff.blank_cnt != 8'h00) begin
            nxt_st.blank_cnt = st_ff.blank_cnt - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.lock_ctrl <= UOF_LOCK_CTRL_RST;
            st_ff.oc_ctrl   <= UOF_OC_CTRL_RST;
            st_ff.mask      <= UOF_MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata  = st_ff.rdata;
    assign pready  = 1'b1;
    assign pslverr = access_ph && !addr_ok;
    assign hs_drive = st_ff.hs_drive;
    assign irq = |(status & st_ff.mask);

    assign dac_cfg.lockout_enable         = st_ff.lock_ctrl[UOF_LOCK_EN_BIT];
    assign dac_cfg.lockout_threshold_code = st_ff.lock_ctrl[5:0];
    assign dac_cfg.overcurrent_enable     = st_ff.oc_ctrl[UOF_OC_EN_BIT];
    assign dac_cfg.blanking_select        = st_ff.oc_ctrl[UOF_BLANK_LSB +: 2];
    assign dac_cfg.current_limit_code     = st_ff.oc_ctrl[4:0];

    a_uv_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.uv_sync && st_ff.lock_ctrl[UOF_LOCK_EN_BIT]
        |=> st_ff.input_low_flag)
        else $error("input low flag not set");

    a_uv_flag_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        !uv_comp_in ##1 !uv_comp_in |=> ##1 !st_ff.input_low_flag)
        else $error("input low flag did not self clear");

    a_uv_flag_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_ff.uv_sync |=> !st_ff.input_low_flag)
        else $error("input low flag held after supply recovered");

    a_uv_disabled: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_ff.lock_ctrl[UOF_LOCK_EN_BIT] |=> !st_ff.input_low_flag)
        else $error("input low flag set while lockout disabled");

    a_lock_en_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_lock |=> dac_cfg.lockout_enable == $past(pwdata[7])
        && dac_cfg.lockout_threshold_code == $past(pwdata[5:0]))
        else $error("lockout control write not applied");

    a_lock_bit6_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        access_ph && !pwrite && paddr == UOF_LOCK_CTRL_OFS
        |-> prdata[6] == 1'b0)
        else $error("lockout bit 6 read nonzero");

    a_rsvd_bit_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_ff.lock_ctrl[UOF_LOCK_RSVD_BIT])
        else $error("lockout bit 6 stored nonzero");

    a_oc_flag_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        oc_event |=> st_ff.overcurrent_flag)
        else $error("overcurrent flag not set on event");

    a_oc_kill: assert property (
        @(posedge pclk) disable iff (!presetn)
        oc_event && !cycle_start
        |=> !hs_drive && st_ff.overcurrent_flag)
        else $error("overcurrent did not end pulse or set flag");

    a_oc_flag_cause: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_ff.overcurrent_flag)
        |-> $past(st_ff.oc_sync && st_ff.hs_drive))
        else $error("overcurrent flag set without conduction");

    a_oc_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        cycle_start && hs_demand |=> hs_drive)
        else $error("high side not restarted at cycle start");

    a_drive_demand: assert property (
        @(posedge pclk) disable iff (!presetn)
        hs_drive |-> $past(hs_demand))
        else $error("high side driven without demand");

    a_oc_resets: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.oc_pending && rd_clr |=> st_ff.overcurrent_flag)
        else $error("overcurrent flag cleared without clean cycle");

    a_oc_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.overcurrent_flag && !rd_clr |=> st_ff.overcurrent_flag)
        else $error("overcurrent flag dropped without software");

    a_read_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_clr && !st_ff.oc_pending && !oc_event
        |=> !st_ff.overcurrent_flag)
        else $error("overcurrent flag not cleared by read");

    a_pending_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.oc_pending && !cycle_start |=> st_ff.oc_pending)
        else $error("pending re-set dropped inside a cycle");

    a_blank_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_ff.hs_drive) |-> st_ff.blank_cnt ==
        uof_blank_cycles($past(st_ff.oc_ctrl[6:5])))
        else $error("blanking count wrong at turn on");

    a_turn_on_blank: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(hs_drive) |-> st_ff.blank_cnt != 8'h00)
        else $error("turn on without blanking");

    a_blank_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.blank_cnt != 8'h00 |-> !oc_event)
        else $error("overcurrent taken during blanking");

    a_blank_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_ff.blank_cnt != 8'h00 && hs_drive && hs_demand |=> hs_drive)
        else $error("high side cut during blanking");

    a_oc_disabled: assert property (
        @(posedge pclk) disable iff (!presetn)
        !dac_cfg.overcurrent_enable |-> !oc_event)
        else $error("overcurrent detected while disabled");

    a_oc_off_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_ff.oc_ctrl[UOF_OC_EN_BIT] && hs_drive && hs_demand
        |=> hs_drive)
        else $error("high side cut while detection disabled");

    a_oc_code_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_oc |=> dac_cfg.current_limit_code == $past(pwdata[4:0]))
        else $error("limit code write not applied");

    a_uv_sync_lat: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(st_ff.input_low_flag) |-> $past(uv_comp_in, 3))
        else $error("input low flag set without synchronised cause");
endmodule // uof_flags
`default_nettype wire

/* File: uof_pkg.sv */
`default_nettype none
package uof_pkg;
    // Register byte addresses
    localparam logic [7:0] UOF_LOCK_CTRL_OFS = 8'h00;
    localparam logic [7:0] UOF_OC_CTRL_OFS   = 8'h04;
    localparam logic [7:0] UOF_STATUS_OFS    = 8'h08;
    localparam logic [7:0] UOF_MASK_OFS      = 8'h0c;
    // Field positions
    localparam int UOF_LOCK_EN_BIT   = 7;
    localparam int UOF_LOCK_RSVD_BIT = 6;
    localparam int UOF_OC_EN_BIT     = 7;
    localparam int UOF_BLANK_LSB     = 5;
    localparam int UOF_ST_LOW_BIT    = 0;
    localparam int UOF_ST_OC_BIT     = 1;
    // Values after reset
    localparam logic [7:0] UOF_LOCK_CTRL_RST = 8'h00;
    localparam logic [7:0] UOF_OC_CTRL_RST   = 8'h00;
    localparam logic [1:0] UOF_MASK_RST      = 2'h0;
    // Clock and blanking times
    localparam int UOF_CLK_PERIOD_NS = 4;
    localparam int UOF_BLANK0_NS     = 114;
    localparam int UOF_BLANK1_NS     = 213;
    localparam int UOF_BLANK2_NS     = 400;
    localparam int UOF_BLANK3_NS     = 780;
    localparam logic [7:0] UOF_BLANK0_CYC = 8'((UOF_BLANK0_NS
        + UOF_CLK_PERIOD_NS - 1) / UOF_CLK_PERIOD_NS);
    localparam logic [7:0] UOF_BLANK1_CYC = 8'((UOF_BLANK1_NS
        + UOF_CLK_PERIOD_NS - 1) / UOF_CLK_PERIOD_NS);
    localparam logic [7:0] UOF_BLANK2_CYC = 8'((UOF_BLANK2_NS
        + UOF_CLK_PERIOD_NS - 1) / UOF_CLK_PERIOD_NS);
    localparam logic [7:0] UOF_BLANK3_CYC = 8'((UOF_BLANK3_NS
        + UOF_CLK_PERIOD_NS - 1) / UOF_CLK_PERIOD_NS);

    // Settings handed to the analog threshold DACs
    typedef struct packed {
        logic       lockout_enable;
        logic [5:0] lockout_threshold_code;
        logic       overcurrent_enable;
        logic [1:0] blanking_select;
        logic [4:0] current_limit_code;
    } uof_dac_t;

    function automatic logic [7:0] uof_blank_cycles(input logic [1:0] sel);
        logic [7:0] c;
        c = UOF_BLANK0_CYC;
        unique case (sel)
            2'h0: c = UOF_BLANK0_CYC;
            2'h1: c = UOF_BLANK1_CYC;
            2'h2: c = UOF_BLANK2_CYC;
            2'h3: c = UOF_BLANK3_CYC;
        endcase
        return c;
    endfunction
endpackage
`default_nettype wire

/* File: uof_flags_test.sv */
`timescale 1ns/100ps
`default_nettype none
module uof_flags_test;
    import uof_pkg::*;
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic        uv_comp_in  = 1'b0;
    logic        oc_comp_in  = 1'b0;
    logic        cycle_start = 1'b0;
    logic        hs_demand   = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hs_drive;
    logic        irq;
    uof_dac_t    dac_cfg;
    logic [31:0] rd;
    logic        err;
    int          num_errors  = 0;
    int          n_checks    = 0;
    int          cnt;
    int          n;
    int          blank_ns [4] = '{114, 213, 400, 780};

    always #2 pclk = ~pclk;

    uof_flags dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uv_comp_in(uv_comp_in), .oc_comp_in(oc_comp_in), .dac_cfg(dac_cfg),
        .cycle_start(cycle_start), .hs_demand(hs_demand),
        .hs_drive(hs_drive), .irq(irq));

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic timed_out(input string what);
        num_errors++;
        $display("Error at %0t: %s timed out", $time, what);
        tally_and_finish();
    endtask

    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timed_out("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_drive(input logic lvl);
        cnt = 0;
        #1;
        while (hs_drive !== lvl) begin
            @(posedge pclk);
            #1;
            cnt++;
            if (cnt > 400) timed_out("high-side drive");
        end
    endtask

    task automatic pulse_start();
        @(posedge pclk);
        cycle_start <= 1'b1;
        @(posedge pclk);
        cycle_start <= 1'b0;
    endtask

    // Fresh turn-on: demand low for a while, then high with a cycle start
    task automatic turn_on();
        repeat (3) @(posedge pclk);
        hs_demand <= 1'b0;
        repeat (3) @(posedge pclk);
        hs_demand <= 1'b1;
        pulse_start();
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b1, UOF_LOCK_CTRL_OFS, 32'hff);
        apb(1'b1, UOF_OC_CTRL_OFS, 32'hff);
        #1 chk(32'(dac_cfg), 32'h7fff, "dac all ones");
        apb(1'b0, UOF_LOCK_CTRL_OFS, 32'h0);
        chk(rd, 32'hbf, "lockout bit 6 zero");
        apb(1'b1, UOF_LOCK_CTRL_OFS, 32'h25);
        apb(1'b1, UOF_OC_CTRL_OFS, 32'h6a);
        #1 chk(32'(dac_cfg), 32'h256a, "dac fields");
        apb(1'b0, UOF_OC_CTRL_OFS, 32'h0);
        chk(rd, 32'h6a, "oc readback");
        apb(1'b1, UOF_LOCK_CTRL_OFS, 32'h40);
        apb(1'b0, UOF_LOCK_CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "lockout bit 6 write");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        $display("registers test done");

        apb(1'b1, UOF_LOCK_CTRL_OFS, 32'h80);
        uv_comp_in <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h1, "input low set");
        #1 chk(32'(irq), 32'h0, "irq masked");
        apb(1'b1, UOF_MASK_OFS, 32'h1);
        #1 chk(32'(irq), 32'h1, "irq unmasked");
        uv_comp_in <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h0, "input low self clear");
        apb(1'b1, UOF_LOCK_CTRL_OFS, 32'h00);
        uv_comp_in <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h0, "lockout disabled");
        uv_comp_in <= 1'b0;
        $display("undervoltage test done");

        apb(1'b1, UOF_MASK_OFS, 32'h2);
        oc_comp_in <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, UOF_OC_CTRL_OFS, 32'h80 | 32'(s << 5));
            turn_on();
            wait_drive(1'b1);
            wait_drive(1'b0);
            n = (blank_ns[s] + 3) / 4;
            chk(cnt, n + 1, "blank time");
        end
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h2, "overcurrent set");
        pulse_start();
        wait_drive(1'b1);
        chk(32'(cnt <= 3), 32'h1, "drive restarts");
        wait_drive(1'b0);
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h2, "clear refused while pending");
        #1 chk(32'(irq), 32'h1, "irq overcurrent");
        oc_comp_in <= 1'b0;
        repeat (4) @(posedge pclk);
        repeat (3) pulse_start();
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h2, "flag sticky");
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h0, "flag cleared by read");
        #1 chk(32'(irq), 32'h0, "irq released");
        $display("overcurrent test done");

        apb(1'b1, UOF_OC_CTRL_OFS, 32'h00);
        oc_comp_in <= 1'b1;
        turn_on();
        repeat (220) @(posedge pclk);
        #1 chk(32'(hs_drive), 32'h1, "detection disabled drive");
        apb(1'b0, UOF_STATUS_OFS, 32'h0);
        chk(rd, 32'h0, "detection disabled flag");
        oc_comp_in <= 1'b0;
        hs_demand <= 1'b0;
        $display("disable test done");
        tally_and_finish();
    end
endmodule // uof_flags_test
`default_nettype wire
